// File: src/etcp_parser.sv
// Purpose: Line-oriented text command interpreter on the device command connection
// Assumes: TCP stack delivers the byte stream; object dictionary formats read text
// Notes:   One character per cycle at most; reply bytes are issued every other cycle
// Contract
// - Service listens on one fixed port; client sends all lines there.
// - Lines end in LF or CR LF; both accepted.
// - Connection closed after about thirty seconds without request or output.
// - Only one client connection at a time; others refused.
// - Each command answered by zero, data or question mark, then CRLF.
// - Not-a-number float result is sent as a question mark.
// - Exactly three commands: object write, object read, FIFO block read.
// - Arguments use object dictionary index, sub-index and value.
// - Object read returns value text with CRLF, or question mark.
// - Successful write answered zero with CRLF; failure with question mark.
// - Action writes still carry a value, which the device ignores.
// - FIFO block read sends header and all data, then clears FIFO.
// - Status vector places each signal at reference number plus one; one invalid.
// - Writing zero to FIFO control flags stops recording and clears fill mode.
`timescale 1ns/100ps
module etcp_parser #(
    parameter longint      TIMEOUT_CYCLES = etcp_pkg::TIMEOUT_CYC,
    parameter logic [15:0] FIFO_CTRL_IDX  = 16'h0000,
    parameter logic [7:0]  FIFO_CTRL_SUB  = 8'h00,
    parameter int          N_SIG          = 24
) (
    input  wire logic              clk_sys,        // System clock
    input  wire logic              rstn,           // Synchronous reset, active low
    output logic [15:0]            listen_port,    // Port the service listens on
    input  wire logic              conn_req,       // New client connection request
    input  wire logic              conn_drop,      // Client closed the connection
    output logic                   conn_refuse,    // Request refused, one busy
    output logic                   conn_active,    // A client is connected
    output logic                   conn_close,     // Idle timeout close pulse
    input  wire logic              rx_valid,       // Received byte valid
    input  wire logic [7:0]        rx_data,        // Received byte
    output logic                   rx_ready,       // Parser takes the byte
    output logic                   tx_valid,       // Reply byte valid
    output logic [7:0]             tx_data,        // Reply byte
    input  wire logic              tx_ready,       // Stack takes the reply byte
    output logic                   od_req,         // Object access request
    output logic                   od_wr,          // High for write
    output logic [15:0]            od_index,       // Object index
    output logic [7:0]             od_subindex,    // Object sub-index
    output logic [31:0]            od_value,       // Write value, digits without point
    output logic [3:0]             od_frac,        // Digits after the decimal point
    input  wire logic              od_ack,         // Access done pulse
    input  wire logic              od_fail,        // Access failed, with ack
    input  wire logic              od_nan,         // Read value is NaN, with ack
    input  wire logic              rd_valid,       // Read text byte valid
    input  wire logic [7:0]        rd_data,        // Read text byte
    input  wire logic              rd_last,        // Last read text byte
    output logic                   rd_ready,       // Read text byte taken
    input  wire logic              fifo_valid,     // FIFO dump byte valid
    input  wire logic [7:0]        fifo_data,      // FIFO dump byte, header first
    input  wire logic              fifo_last,      // Last FIFO dump byte
    output logic                   fifo_ready,     // FIFO dump byte taken
    output logic                   fifo_clear,     // Clear FIFO pulse
    output logic                   fifo_stop,      // Stop recording, clear fill mode
    input  wire logic [N_SIG-1:0]  sig_invalid,    // Per signal reference, one invalid
    output logic [N_SIG:0]         status_vector   // Measurement status word
);
    localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYCLES - 1);

    if (TIMEOUT_CYCLES < 2 || N_SIG < 1 || N_SIG > 31) begin : g_check
        $error("etcp_parser: unsupported parameter value");
    end

    typedef struct packed {
        etcp_pkg::etcp_state_type st;
        logic [31:0]   kw;
        logic          kwdone;
        logic [1:0]    argn;
        logic          dig;
        logic [31:0]   acc;
        logic          hex;
        logic          neg;
        logic          dot;
        logic [3:0]    frac;
        logic          inq;
        logic          cr;
        logic          err;
        logic [5:0]    len;
        logic [15:0]   idx;
        logic [7:0]    sub;
        logic [31:0]   val;
        logic [3:0]    vfrac;
        logic          wr;
        logic [7:0]    code;
        logic          ovld;
        logic [7:0]    obyte;
        logic [TW-1:0] tmo;
        logic          conn;
        logic          odreq;
        logic          fclr;
        logic          fstop;
        logic          close;
        logic [N_SIG:0] stat;
    } etcp_regs_type;

    etcp_regs_type r_reg, r_next;

    function automatic etcp_regs_type clear_line(input etcp_regs_type s);
        etcp_regs_type t;
        t = s;
        {t.kw, t.kwdone, t.argn, t.dig, t.acc} = '0;
        {t.hex, t.neg, t.dot, t.frac, t.inq, t.cr, t.err, t.len} = '0;
        return t;
    endfunction

    function automatic etcp_regs_type store_arg(input etcp_regs_type s);
        etcp_regs_type t;
        t = s;
        if (!s.dig) begin
            t.err = 1'b1;
        end else begin
            unique case (s.argn)
                2'd0: t.idx = s.acc[15:0];
                2'd1: t.sub = s.acc[7:0];
                2'd2: begin
                    t.val   = s.neg ? 32'(-s.acc) : s.acc;
                    t.vfrac = s.frac;
                end
                default: t.err = 1'b1;
            endcase
            t.argn = (s.argn == 2'd3) ? s.argn : s.argn + 2'd1;
        end
        {t.dig, t.acc, t.hex, t.neg, t.dot, t.frac} = '0;
        return t;
    endfunction

    logic rx_fire;
    logic tx_fire;
    logic is_dec;
    logic is_hex;
    logic [7:0] dval;

    assign rx_ready    = r_reg.conn && r_reg.st == etcp_pkg::ST_COLLECT;
    assign rx_fire     = rx_valid && rx_ready;
    assign tx_fire     = r_reg.ovld && tx_ready;
    assign rd_ready    = r_reg.st == etcp_pkg::ST_STREAM_RD && !r_reg.ovld;
    assign fifo_ready  = r_reg.st == etcp_pkg::ST_STREAM_FIFO && !r_reg.ovld;
    assign conn_refuse = conn_req && r_reg.conn;
    assign is_dec      = rx_data >= etcp_pkg::CHR_ZERO && rx_data <= etcp_pkg::CHR_NINE;
    assign is_hex      = (rx_data >= etcp_pkg::CHR_UA && rx_data <= etcp_pkg::CHR_UF)
                      || (rx_data >= etcp_pkg::CHR_LA && rx_data <= etcp_pkg::CHR_LF_HEX);
    assign dval        = is_dec ? rx_data - etcp_pkg::CHR_ZERO
                       : (rx_data & 8'hdf) - etcp_pkg::CHR_UA + etcp_pkg::HEX_ALPHA_OFS;

    always_comb begin
        r_next       = r_reg;
        r_next.fclr  = 1'b0;
        r_next.fstop = 1'b0;
        r_next.close = 1'b0;
        r_next.stat  = {sig_invalid, 1'b0};
        r_next.tmo   = r_reg.conn ? r_reg.tmo + TW'(1) : '0;
        if (tx_fire) begin
            r_next.ovld = 1'b0;
        end
        if (rx_fire || tx_fire) begin
            r_next.tmo = '0;
        end
        if (rx_fire) begin
            r_next.len = (r_reg.len == etcp_pkg::MAX_LINE) ? r_reg.len : r_reg.len + 6'd1;
            if (rx_data == etcp_pkg::CHR_LF) begin
                r_next = r_reg.kwdone && !r_reg.inq ? store_arg(r_next) : r_next;
                if (r_reg.dig == 1'b0 && r_reg.argn != 2'd0) begin
                    r_next.err = 1'b1;
                end
                if (!r_reg.kwdone && r_reg.kw != '0) begin
                    r_next.argn = '0;
                    r_next.err  = r_reg.err || r_reg.inq;
                end
                r_next.code = etcp_pkg::CHR_QMARK;
                r_next.st   = etcp_pkg::ST_REPLY;
                if (r_reg.len >= etcp_pkg::MAX_LINE || r_next.err || r_reg.inq) begin
                    r_next.st = etcp_pkg::ST_REPLY;
                end else if (r_reg.kw == etcp_pkg::KW_WRITE
                             && r_next.argn == 2'(etcp_pkg::NARG_WRITE)) begin
                    r_next.wr    = 1'b1;
                    r_next.odreq = 1'b1;
                    r_next.st    = etcp_pkg::ST_OD_WAIT;
                end else if (r_reg.kw == etcp_pkg::KW_READ
                             && r_next.argn == 2'(etcp_pkg::NARG_READ)) begin
                    r_next.wr    = 1'b0;
                    r_next.odreq = 1'b1;
                    r_next.st    = etcp_pkg::ST_OD_WAIT;
                end else if (r_reg.kw == etcp_pkg::KW_FIFO
                             && r_next.argn == 2'(etcp_pkg::NARG_FIFO)) begin
                    r_next.st = etcp_pkg::ST_STREAM_FIFO;
                end
                r_next = clear_line(r_next);
            end else if (r_reg.cr) begin
                r_next.err = 1'b1;
            end else if (rx_data == etcp_pkg::CHR_CR) begin
                r_next.cr = 1'b1;
            end else if (r_reg.inq) begin
                if (rx_data == etcp_pkg::CHR_DQUOTE) begin
                    r_next.inq = 1'b0;
                end else if (rx_data == etcp_pkg::CHR_QMARK
                             || rx_data == etcp_pkg::CHR_SQUOTE) begin
                    r_next.err = 1'b1;
                end
            end else if (!r_reg.kwdone) begin
                if (rx_data == etcp_pkg::CHR_SPACE && r_reg.kw != '0) begin
                    r_next.kwdone = 1'b1;
                end else if (((rx_data >= etcp_pkg::CHR_UA && rx_data <= etcp_pkg::CHR_UZ)
                              || rx_data == etcp_pkg::CHR_QMARK) && r_reg.kw[31:24] == '0) begin
                    r_next.kw = {r_reg.kw[23:0], rx_data};
                end else begin
                    r_next.err = 1'b1;
                end
            end else if (rx_data == etcp_pkg::CHR_COMMA) begin
                r_next = store_arg(r_next);
            end else if (rx_data == etcp_pkg::CHR_DQUOTE && !r_reg.dig) begin
                r_next.inq = 1'b1;
                r_next.dig = 1'b1;
            end else if ((rx_data == etcp_pkg::CHR_LX || rx_data == etcp_pkg::CHR_UX)
                         && r_reg.dig && r_reg.acc == '0 && !r_reg.hex && !r_reg.dot) begin
                r_next.hex = 1'b1;
            end else if (rx_data == etcp_pkg::CHR_MINUS && !r_reg.dig) begin
                r_next.neg = 1'b1;
            end else if (rx_data == etcp_pkg::CHR_DOT && !r_reg.hex && !r_reg.dot) begin
                r_next.dot = 1'b1;
            end else if (is_dec || (is_hex && r_reg.hex)) begin
                r_next.dig  = 1'b1;
                r_next.acc  = r_reg.hex ? {r_reg.acc[27:0], dval[3:0]}
                                        : 32'(r_reg.acc * etcp_pkg::DEC_BASE + 32'(dval));
                r_next.frac = r_reg.dot ? r_reg.frac + 4'd1 : r_reg.frac;
            end else if (rx_data != etcp_pkg::CHR_SPACE) begin
                r_next.err = 1'b1;
            end
        end
        unique case (r_reg.st)
            etcp_pkg::ST_COLLECT: ;
            etcp_pkg::ST_OD_WAIT: begin
                if (od_ack) begin
                    r_next.odreq = 1'b0;
                    r_next.code  = (od_fail || od_nan) ? etcp_pkg::CHR_QMARK
                                                       : etcp_pkg::CHR_ZERO;
                    r_next.st    = (r_reg.wr || od_fail || od_nan) ? etcp_pkg::ST_REPLY
                                                                    : etcp_pkg::ST_STREAM_RD;
                    r_next.fstop = r_reg.wr && !od_fail && r_reg.idx == FIFO_CTRL_IDX
                                && r_reg.sub == FIFO_CTRL_SUB && r_reg.val == '0;
                end
            end
            etcp_pkg::ST_STREAM_RD: begin
                if (rd_ready && rd_valid) begin
                    r_next.ovld  = 1'b1;
                    r_next.obyte = rd_data;
                    r_next.st    = rd_last ? etcp_pkg::ST_SEND_CR : r_reg.st;
                end
            end
            etcp_pkg::ST_STREAM_FIFO: begin
                if (fifo_ready && fifo_valid) begin
                    r_next.ovld  = 1'b1;
                    r_next.obyte = fifo_data;
                    r_next.fclr  = fifo_last;
                    r_next.st    = fifo_last ? etcp_pkg::ST_SEND_CR : r_reg.st;
                end
            end
            etcp_pkg::ST_REPLY, etcp_pkg::ST_SEND_CR, etcp_pkg::ST_SEND_LF: begin
                if (!r_reg.ovld) begin
                    r_next.ovld = 1'b1;
                    unique case (r_reg.st)
                        etcp_pkg::ST_REPLY:   r_next.obyte = r_reg.code;
                        etcp_pkg::ST_SEND_CR: r_next.obyte = etcp_pkg::CHR_CR;
                        default:              r_next.obyte = etcp_pkg::CHR_LF;
                    endcase
                    r_next.st = r_reg.st == etcp_pkg::ST_REPLY   ? etcp_pkg::ST_SEND_CR
                              : r_reg.st == etcp_pkg::ST_SEND_CR ? etcp_pkg::ST_SEND_LF
                                                                 : etcp_pkg::ST_COLLECT;
                end
            end
        endcase
        // Closing abandons any reply in flight; a late od_ack is then ignored
        if ((r_reg.conn && r_reg.tmo == TMO_LAST) || conn_drop) begin
            r_next       = clear_line(r_next);
            r_next.close = r_reg.conn && r_reg.tmo == TMO_LAST;
            r_next.conn  = 1'b0;
            r_next.st    = etcp_pkg::ST_COLLECT;
            r_next.ovld  = 1'b0;
            r_next.odreq = 1'b0;
            r_next.tmo   = '0;
        end else if (conn_req && !r_reg.conn) begin
            r_next.conn = 1'b1;
            r_next.tmo  = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            r_reg    <= '0;
            r_reg.st <= etcp_pkg::ST_COLLECT;
        end else begin
            r_reg <= r_next;
        end
    end

    assign listen_port   = etcp_pkg::CMD_PORT;
    assign conn_active   = r_reg.conn;
    assign conn_close    = r_reg.close;
    assign tx_valid      = r_reg.ovld;
    assign tx_data       = r_reg.obyte;
    assign od_req        = r_reg.odreq;
    assign od_wr         = r_reg.wr;
    assign od_index      = r_reg.idx;
    assign od_subindex   = r_reg.sub;
    assign od_value      = r_reg.val;
    assign od_frac       = r_reg.vfrac;
    assign fifo_clear    = r_reg.fclr;
    assign fifo_stop     = r_reg.fstop;
    assign status_vector = r_reg.stat;

    a_refuse_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
        conn_req && conn_active |=> conn_active) else $error("second client disturbed link");
    a_idle_close: assert property (@(posedge clk_sys) disable iff (!rstn)
        conn_active && r_reg.tmo == TMO_LAST && !conn_drop |=> conn_close && !conn_active)
        else $error("idle connection not closed");
    a_lf_follows_cr: assert property (@(posedge clk_sys) disable iff (!rstn)
        tx_fire && tx_data == etcp_pkg::CHR_CR && !conn_drop && r_reg.tmo != TMO_LAST
        |-> ##[1:4] (tx_valid && tx_data == etcp_pkg::CHR_LF) || !conn_active)
        else $error("CR not followed by LF");
    a_overlong_qmark: assert property (@(posedge clk_sys) disable iff (!rstn)
        rx_fire && rx_data == etcp_pkg::CHR_LF && r_reg.len >= etcp_pkg::MAX_LINE
        && !conn_drop && r_reg.tmo != TMO_LAST
        |=> ##1 tx_valid && tx_data == etcp_pkg::CHR_QMARK) else $error("overlong line accepted");
    a_od_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        od_req && !od_ack && !conn_drop && r_reg.tmo != TMO_LAST
        |=> od_req && $stable(od_index) && $stable(od_subindex) && $stable(od_value))
        else $error("object request not held");
    a_fifo_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
        fifo_valid && fifo_ready && fifo_last |=> fifo_clear) else $error("FIFO not cleared");
    a_fifo_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
        r_reg.st == etcp_pkg::ST_OD_WAIT && od_ack && !od_fail && od_wr
        && od_index == FIFO_CTRL_IDX && od_subindex == FIFO_CTRL_SUB && od_value == '0
        && !conn_drop && r_reg.tmo != TMO_LAST |=> fifo_stop) else $error("FIFO stop missing");
    a_nan_qmark: assert property (@(posedge clk_sys) disable iff (!rstn)
        r_reg.st == etcp_pkg::ST_OD_WAIT && od_ack && od_nan && !conn_drop
        && r_reg.tmo != TMO_LAST |=> ##1 tx_valid && tx_data == etcp_pkg::CHR_QMARK)
        else $error("NaN not sent as question mark");
    a_status_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        ##1 status_vector == {$past(sig_invalid), 1'b0}) else $error("status bit misplaced");
endmodule // etcp_parser

// File: common/etcp_pkg.sv
// Purpose: Constants and types shared by the text command parser
// Assumes: 8-bit ASCII byte stream, 250 MHz system clock
// Notes:   Keywords are packed right-aligned, first character in the highest used byte
package etcp_pkg;
    localparam logic [15:0] CMD_PORT      = 16'hd6d8;     // Listening port 55000
    localparam logic [7:0]  CHR_LF        = 8'h0a;
    localparam logic [7:0]  CHR_CR        = 8'h0d;
    localparam logic [7:0]  CHR_SPACE     = 8'h20;
    localparam logic [7:0]  CHR_DQUOTE    = 8'h22;
    localparam logic [7:0]  CHR_SQUOTE    = 8'h27;
    localparam logic [7:0]  CHR_COMMA     = 8'h2c;
    localparam logic [7:0]  CHR_MINUS     = 8'h2d;
    localparam logic [7:0]  CHR_DOT       = 8'h2e;
    localparam logic [7:0]  CHR_ZERO      = 8'h30;
    localparam logic [7:0]  CHR_NINE      = 8'h39;
    localparam logic [7:0]  CHR_QMARK     = 8'h3f;
    localparam logic [7:0]  CHR_UA        = 8'h41;
    localparam logic [7:0]  CHR_UF        = 8'h46;
    localparam logic [7:0]  CHR_UZ        = 8'h5a;
    localparam logic [7:0]  CHR_LA        = 8'h61;
    localparam logic [7:0]  CHR_LF_HEX    = 8'h66;
    localparam logic [7:0]  CHR_LX        = 8'h78;
    localparam logic [7:0]  CHR_UX        = 8'h58;
    localparam logic [7:0]  HEX_ALPHA_OFS = 8'h0a;
    localparam logic [5:0]  MAX_LINE      = 6'h28;        // 40 characters with terminator
    localparam logic [31:0] KW_WRITE      = 32'h0053444f;
    localparam logic [31:0] KW_READ       = 32'h53444f3f;
    localparam logic [31:0] KW_FIFO       = 32'h524d423f; // fifo_block_read_cmd
    localparam logic [31:0] DEC_BASE      = 32'h0000000a;
    localparam int unsigned NARG_WRITE    = 3;
    localparam int unsigned NARG_READ     = 2;
    localparam int unsigned NARG_FIFO     = 0;
    localparam longint      TIMEOUT_S     = 30;
    localparam longint      CLK_HZ        = 250000000;
    localparam longint      TIMEOUT_CYC   = TIMEOUT_S * CLK_HZ;

    typedef enum logic [2:0] {
        ST_COLLECT,
        ST_OD_WAIT,
        ST_STREAM_RD,
        ST_STREAM_FIFO,
        ST_REPLY,
        ST_SEND_CR,
        ST_SEND_LF
    } etcp_state_type;
endpackage

// File: tb/etcp_od_model.sv
// Purpose: Object dictionary and FIFO source facing the command parser
// Assumes: Index ffff fails, index fffe reads as NaN, others succeed
// Notes:   Answers after four cycles so the parser really waits
`timescale 1ns/100ps
module etcp_od_model (
    input  wire logic        clk_sys,    // System clock
    input  wire logic        rstn,       // Synchronous reset, active low
    input  wire logic        od_req,     // Access request
    input  wire logic        od_wr,      // High for write
    input  wire logic [15:0] od_index,   // Object index
    output logic             od_ack,     // Access done pulse
    output logic             od_fail,    // Access failed
    output logic             od_nan,     // Read value is NaN
    output logic             rd_valid,   // Read text byte valid
    output logic [7:0]       rd_data,    // Read text byte
    output logic             rd_last,    // Last read text byte
    input  wire logic        rd_ready,   // Read byte taken
    output logic             fifo_valid, // FIFO byte valid
    output logic [7:0]       fifo_data,  // FIFO byte
    output logic             fifo_last,  // Last FIFO byte
    input  wire logic        fifo_ready  // FIFO byte taken
);
    logic [1:0] cnt_reg;
    logic       rp_reg;
    logic [1:0] fp_reg;
    always_ff @(posedge clk_sys) begin
        od_ack <= 1'b0;
        if (!rstn) begin
            cnt_reg <= 2'h0;
            rp_reg <= 1'b0;
            fp_reg <= 2'h0;
            rd_valid <= 1'b0;
            od_fail <= 1'b0;
            od_nan <= 1'b0;
        end else begin
            if (od_req && !od_ack) cnt_reg <= cnt_reg + 2'h1;
            if (cnt_reg == 2'h3) begin
                cnt_reg <= 2'h0;
                od_ack <= 1'b1;
                od_fail <= (od_index == 16'hffff);
                od_nan <= !od_wr && (od_index == 16'hfffe);
                rd_valid <= !od_wr && (od_index < 16'hfffe);
            end
            if (rd_valid && rd_ready) rp_reg <= !rp_reg;
            if (rd_valid && rd_ready && rp_reg) rd_valid <= 1'b0;
            if (fifo_ready) fp_reg <= (fp_reg == 2'h2) ? 2'h0 : fp_reg + 2'h1;
        end
    end
    // Released text line shows the inverse so a stale sample cannot match
    assign rd_data    = rd_valid ? 8'h31 + {7'h0, rp_reg} : ~(8'h31 + {7'h0, rp_reg});
    assign rd_last    = rd_valid && rp_reg;
    assign fifo_valid = 1'b1;
    assign fifo_data  = 8'h48 + {6'h0, fp_reg};
    assign fifo_last  = (fp_reg == 2'h2);
endmodule // etcp_od_model

// File: tb/tb.sv
// Purpose: Self-checking bench of the text command parser
// Assumes: Idle timeout shortened to 200 cycles
// Notes:   Inputs change on the falling clock phase; the reply stack stalls once
`timescale 1ns/100ps
module tb;
    logic clk_sys, rstn, conn_req, conn_refuse, conn_active, conn_close, rx_valid, rx_ready;
    logic tx_valid, od_req, od_wr, od_ack, od_fail, od_nan, rd_valid, rd_last, rd_ready;
    logic fifo_valid, fifo_last, fifo_ready, fifo_clear, fifo_stop, clr_seen, stop_seen;
    logic conn_drop, tx_ready;
    logic [7:0]  rx_data, tx_data, od_subindex, rd_data, fifo_data;
    logic [15:0] listen_port, od_index;
    logic [31:0] od_value;
    logic [23:0] sig_invalid;
    logic [24:0] status_vector;
    int          num_errors, num_checks;
    etcp_parser #(.TIMEOUT_CYCLES(200)) dut (.clk_sys, .rstn, .listen_port, .conn_req,
        .conn_drop, .conn_refuse, .conn_active, .conn_close, .rx_valid, .rx_data,
        .rx_ready, .tx_valid, .tx_data, .tx_ready, .od_req, .od_wr, .od_index,
        .od_subindex, .od_value, .od_frac(), .od_ack, .od_fail, .od_nan, .rd_valid, .rd_data,
        .rd_last, .rd_ready, .fifo_valid, .fifo_data, .fifo_last, .fifo_ready, .fifo_clear,
        .fifo_stop, .sig_invalid, .status_vector);
    etcp_od_model u_od (.clk_sys, .rstn, .od_req, .od_wr, .od_index, .od_ack, .od_fail,
        .od_nan, .rd_valid, .rd_data, .rd_last, .rd_ready, .fifo_valid, .fifo_data,
        .fifo_last, .fifo_ready);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Pulses are latched here so tasks need not hit their exact cycle
    always @(negedge clk_sys) begin
        if (!rstn) begin
            clr_seen <= 1'b0;
            stop_seen <= 1'b0;
        end else begin
            if (fifo_clear === 1'b1) clr_seen <= 1'b1;
            if (fifo_stop === 1'b1) stop_seen <= 1'b1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send_line(input string s);
        int n;
        for (int i = 0; i < s.len(); i++) begin
            rx_valid = 1'b1;
            rx_data = s[i];
            for (n = 0; n < 400 && rx_ready !== 1'b1; n++) @(negedge clk_sys);
            if (n == 400) num_errors++;
            @(negedge clk_sys);
        end
        rx_valid = 1'b0;
    endtask
    task automatic cmd(input string s, input string e);
        int n;
        if (s.len() > 0) send_line(s);
        for (int i = 0; i < e.len(); i++) begin
            for (n = 0; n < 400 && tx_valid !== 1'b1; n++) @(negedge clk_sys);
            chk({tx_valid, tx_data}, {1'b1, e[i]});
            @(negedge clk_sys);
        end
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic t_connect();
        conn_req = 1'b1;
        @(negedge clk_sys);
        chk(conn_active, 1'b1);
        chk(listen_port, 16'hd6d8);
        #1 chk(conn_refuse, 1'b1);
        @(negedge clk_sys);
        conn_req = 1'b0;
    endtask
    task automatic t_write();
        send_line("SDO 0x4401,2,-5\n");
        chk(od_req, 1'b1);
        chk({od_wr, od_index, od_subindex}, {1'b1, 16'h4401, 8'h02});
        chk(od_value, -32'sd5);
        cmd("", "0\r\n");
    endtask
    task automatic t_lines();
        cmd("SDO 0x4410,4,0\r\n", "0\r\n");
        cmd("SDO 0xffff,1,7\n", "?\r\n");
        cmd("SDO? 0x44f4,1\r\n", "12\r\n");
        cmd("SDO? 0xfffe,1\n", "?\r\n");
        cmd("XYZ 1\n", "?\r\n");
        cmd("SDO 1,2,3,4\n", "?\r\n");
        cmd("SDO? 1,1111111111111111111111111111111111\n", "?\r\n");
        cmd("SDO 0x4400,1,0000000000000000000000000\r\n", "0\r\n");
        cmd("SDO 0x4000,1,\"ab\"\n", "0\r\n");
        cmd("SDO 1,1,\"a?\"\n", "?\r\n");
        cmd("SDO 0,0,0\n", "0\r\n");
        chk(stop_seen, 1'b1);
        cmd("RMB?\n", "HIJ\r\n");
        chk(clr_seen, 1'b1);
    endtask
    task automatic t_status_idle();
        int n;
        sig_invalid = 24'h00_f00d;
        repeat (2) @(negedge clk_sys);
        chk(status_vector, {24'h00_f00d, 1'b0});
        for (n = 0; n < 300 && conn_close !== 1'b1; n++) @(negedge clk_sys);
        chk(conn_close, 1'b1);
        @(negedge clk_sys);
        chk(conn_active, 1'b0);
    endtask
    // A drop mid-line must leave no stale keyword; a stalled reply byte must stand
    task automatic t_drop_stall();
        conn_req = 1'b1;
        @(negedge clk_sys);
        conn_req = 1'b0;
        send_line("SDO? 1");
        conn_drop = 1'b1;
        @(negedge clk_sys);
        conn_drop = 1'b0;
        chk({conn_active, conn_close}, 2'b00);
        conn_req = 1'b1;
        @(negedge clk_sys);
        conn_req = 1'b0;
        tx_ready = 1'b0;
        send_line(",1\n");
        repeat (4) @(negedge clk_sys);
        chk({tx_valid, tx_data}, {1'b1, etcp_pkg::CHR_QMARK});
        tx_ready = 1'b1;
        @(negedge clk_sys);
        cmd("", "\r\n");
    endtask
    initial begin
        {rstn, conn_req, conn_drop, rx_valid, rx_data, sig_invalid} = '0;
        tx_ready = 1'b1;
        repeat (6) @(negedge clk_sys);
        rstn = 1'b1;
        t_connect();
        t_write();
        t_lines();
        t_status_idle();
        t_drop_stall();
        end_of_test();
    end
    initial begin
        #80000;
        num_errors++;
        end_of_test();
    end
endmodule // tb
